// File: rtl/ppc_consts.vh
// Overview of operation
// - low bit zero: word is interrupt vector
// - low four bits ones: mode selection word
// - bit control mode: next word sets directions
// - direction bit one input, zero output
// - low nibble 0111: interrupt control word
// - bit control interrupts from input levels
// - bit six chooses and or or
// - bit five chooses active level
// - bit four: next word is mask
// - control word bit four clears pending
// - enable waits for machine cycle one strobe
// - mask bit one excludes the line
// - low nibble 0011: enable word only
// - two identical ports a and b, a ahead of b in interrupt priority
// - reset: input mode, interrupts disabled
// - strobe with request: acknowledge, drive vector
// - fetch cycles watched for return opcode
// - port a data 0, command 1
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH
`define PPC_ADDR_A_DATA 4'h0
`define PPC_ADDR_A_CMD 4'h1
`define PPC_ADDR_B_DATA 4'h2
`define PPC_ADDR_B_CMD 4'h3
`define PPC_MODE_OUT 2'h0
`define PPC_MODE_IN 2'h1
`define PPC_MODE_BIDIR 2'h2
`define PPC_MODE_BIT 2'h3
`define PPC_MODE_MSB 7
`define PPC_MODE_LSB 6
`define PPC_ICW_FUNC_BIT 6
`define PPC_ICW_LEVEL_BIT 5
`define PPC_ICW_MASK_BIT 4
`define PPC_ICW_ENABLE_BIT 7
`define PPC_ICW_CODE 4'h7
`define PPC_IEN_CODE 4'h3
`define PPC_MODE_CODE 3'h7
`define PPC_RESET_MODE 2'h1
`define PPC_RESET_DIR 8'hFF
`define PPC_RESET_MASK 8'h00
`define PPC_OPC_PREFIX 8'hED
`define PPC_OPC_RETURN 8'h4D
`endif

// File: rtl/ppc_port.v
`timescale 1ns/1ns
`include "ppc_consts.vh"
module ppc_port
(
   input wire clock_i,
   input wire rst_i,
   input wire cmd_wr_i,
   input wire [7:0] cmd_data_i,
   input wire data_wr_i,
   input wire cycle_one_i,
   input wire ack_i,
   input wire ret_done_i,
   input wire [7:0] pins_i,
   output reg [7:0] vector_o,
   output reg [1:0] mode_o,
   output reg [7:0] dir_o,
   output reg [7:0] out_o,
   output reg int_req_o,
   output reg in_service_o
);
   // ----------------------------------------
   // command decode state
   // ----------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_DIR = 2'h1;
   localparam ST_MASK = 2'h2;
   reg [1:0] state_reg;
   reg func_and_reg;
   reg level_high_reg;
   reg [7:0] mask_reg;
   reg enable_reg;
   reg armed_reg;
   reg pending_reg;
   reg cond_prev_reg;
   wire [7:0] active_lines;
   wire cond_and;
   wire cond_or;
   wire cond_now;
   // ----------------------------------------
   // interrupt condition
   // ----------------------------------------
   assign active_lines = (level_high_reg ? pins_i : ~pins_i) & dir_o & ~mask_reg;
   // and form needs every unmasked input line active, and at least one such line
   assign cond_and = ((active_lines | mask_reg | ~dir_o) == 8'hFF) && ((dir_o & ~mask_reg) != 8'h00);
   assign cond_or = |active_lines;
   assign cond_now = (mode_o == `PPC_MODE_BIT) && (func_and_reg ? cond_and : cond_or);
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         vector_o <= 8'h00;
         mode_o <= `PPC_RESET_MODE;
         dir_o <= `PPC_RESET_DIR;
         out_o <= 8'h00;
         func_and_reg <= 1'b0;
         level_high_reg <= 1'b0;
         mask_reg <= `PPC_RESET_MASK;
         enable_reg <= 1'b0;
         armed_reg <= 1'b0;
         pending_reg <= 1'b0;
         cond_prev_reg <= 1'b0;
         int_req_o <= 1'b0;
         in_service_o <= 1'b0;
      end
      else
      begin
         cond_prev_reg <= cond_now;
         if (data_wr_i)
            out_o <= cmd_data_i;
         if (cmd_wr_i)
         begin
            case (state_reg)
               ST_DIR:
               begin
                  dir_o <= cmd_data_i;
                  state_reg <= ST_IDLE;
               end
               ST_MASK:
               begin
                  mask_reg <= cmd_data_i;
                  state_reg <= ST_IDLE;
               end
               default:
               begin
                  if (!cmd_data_i[0])
                     vector_o <= {cmd_data_i[7:1], 1'b0};
                  else if (cmd_data_i[3:0] == `PPC_ICW_CODE)
                  begin
                     func_and_reg <= cmd_data_i[`PPC_ICW_FUNC_BIT];
                     level_high_reg <= cmd_data_i[`PPC_ICW_LEVEL_BIT];
                     enable_reg <= cmd_data_i[`PPC_ICW_ENABLE_BIT];
                     armed_reg <= 1'b0;
                     if (cmd_data_i[`PPC_ICW_MASK_BIT])
                        state_reg <= ST_MASK;
                  end
                  else if (cmd_data_i[3:0] == `PPC_IEN_CODE)
                  begin
                     enable_reg <= cmd_data_i[`PPC_ICW_ENABLE_BIT];
                     armed_reg <= 1'b0;
                  end
                  else if (cmd_data_i[2:0] == `PPC_MODE_CODE)
                  begin
                     mode_o <= cmd_data_i[`PPC_MODE_MSB:`PPC_MODE_LSB];
                     if (cmd_data_i[`PPC_MODE_MSB:`PPC_MODE_LSB] == `PPC_MODE_BIT)
                        state_reg <= ST_DIR;
                     else if (cmd_data_i[`PPC_MODE_MSB:`PPC_MODE_LSB] == `PPC_MODE_OUT)
                        dir_o <= 8'h00;
                     else
                        dir_o <= `PPC_RESET_DIR;
                  end
               end
            endcase
         end
         else if (cycle_one_i && enable_reg)
            armed_reg <= 1'b1;
         // a new condition edge sets pending; set wins over the clear
         if (cond_now && !cond_prev_reg && enable_reg && armed_reg)
            pending_reg <= 1'b1;
         else if (cmd_wr_i && state_reg == ST_IDLE && cmd_data_i[3:0] == `PPC_ICW_CODE
                  && cmd_data_i[`PPC_ICW_MASK_BIT])
            pending_reg <= 1'b0;
         else if (ack_i && int_req_o)
            pending_reg <= 1'b0;
         if (ack_i && int_req_o)
            in_service_o <= 1'b1;
         else if (ret_done_i)
            in_service_o <= 1'b0;
         int_req_o <= pending_reg && enable_reg && armed_reg && !(ack_i && int_req_o);
      end
   end
endmodule // ppc_port

// File: rtl/ppc_top.v
`timescale 1ns/1ns
`include "ppc_consts.vh"
module ppc_top
(
   input wire clock_i,
   input wire rst_i,
   input wire cs_n_i,
   input wire io_request_strobe_n_i,
   input wire rd_n_i,
   input wire machine_cycle_one_strobe_n_i,
   input wire [3:0] register_select_lines_i,
   input wire [7:0] data_i,
   output reg [7:0] data_o,
   output reg data_oe_o,
   input wire [7:0] port_a_i,
   output reg [7:0] port_a_o,
   output reg [7:0] port_a_oe_o,
   input wire [7:0] port_b_i,
   output reg [7:0] port_b_o,
   output reg [7:0] port_b_oe_o,
   output reg int_n_o
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // strobes are level inputs; an access counts once, on its first cycle
   reg access_prev_reg;
   reg ack_prev_reg;
   reg fetch_prev_reg;
   reg prefix_seen_reg;
   wire sel_access;
   wire access_start;
   wire ack_now;
   wire ack_start;
   wire fetch_now;
   wire fetch_start;
   wire wr_cyc;
   wire a_cmd_wr;
   wire b_cmd_wr;
   wire a_data_wr;
   wire b_data_wr;
   wire ret_seen;
   wire [7:0] vec_a;
   wire [7:0] vec_b;
   wire [1:0] mode_a;
   wire [1:0] mode_b;
   wire [7:0] dir_a;
   wire [7:0] dir_b;
   wire [7:0] out_a;
   wire [7:0] out_b;
   wire req_a;
   wire req_b;
   wire svc_a;
   wire svc_b;
   assign sel_access = !cs_n_i && !io_request_strobe_n_i && machine_cycle_one_strobe_n_i;
   assign access_start = sel_access && !access_prev_reg;
   assign wr_cyc = access_start && rd_n_i;
   assign a_cmd_wr = wr_cyc && register_select_lines_i == `PPC_ADDR_A_CMD;
   assign b_cmd_wr = wr_cyc && register_select_lines_i == `PPC_ADDR_B_CMD;
   assign a_data_wr = wr_cyc && register_select_lines_i == `PPC_ADDR_A_DATA;
   assign b_data_wr = wr_cyc && register_select_lines_i == `PPC_ADDR_B_DATA;
   assign ack_now = !machine_cycle_one_strobe_n_i && !io_request_strobe_n_i;
   assign ack_start = ack_now && !ack_prev_reg;
   assign fetch_now = !machine_cycle_one_strobe_n_i && !rd_n_i && io_request_strobe_n_i;
   assign fetch_start = fetch_now && !fetch_prev_reg;
   assign ret_seen = fetch_start && prefix_seen_reg && data_i == `PPC_OPC_RETURN;
   // input lines read the pins, output lines the latch
   function [7:0] read_value;
      input [7:0] pins;
      input [7:0] latch;
      input [7:0] dir;
      begin
         read_value = (pins & dir) | (latch & ~dir);
      end
   endfunction
   // ----------------------------------------
   // two identical ports
   // ----------------------------------------
   ppc_port u_port_a
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .cmd_wr_i(a_cmd_wr),
      .cmd_data_i(data_i),
      .data_wr_i(a_data_wr),
      .cycle_one_i(!machine_cycle_one_strobe_n_i),
      .ack_i(ack_start),
      .ret_done_i(ret_seen && svc_a),
      .pins_i(port_a_i),
      .vector_o(vec_a),
      .mode_o(mode_a),
      .dir_o(dir_a),
      .out_o(out_a),
      .int_req_o(req_a),
      .in_service_o(svc_a)
   );
   // b sees acknowledge only when a is not asking: a has priority
   ppc_port u_port_b
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .cmd_wr_i(b_cmd_wr),
      .cmd_data_i(data_i),
      .data_wr_i(b_data_wr),
      .cycle_one_i(!machine_cycle_one_strobe_n_i),
      .ack_i(ack_start && !req_a),
      .ret_done_i(ret_seen && svc_b && !svc_a),
      .pins_i(port_b_i),
      .vector_o(vec_b),
      .mode_o(mode_b),
      .dir_o(dir_b),
      .out_o(out_b),
      .int_req_o(req_b),
      .in_service_o(svc_b)
   );
   // ----------------------------------------
   // bus answers and pins
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         access_prev_reg <= 1'b0;
         ack_prev_reg <= 1'b0;
         fetch_prev_reg <= 1'b0;
         prefix_seen_reg <= 1'b0;
         data_o <= 8'h00;
         data_oe_o <= 1'b0;
         port_a_o <= 8'h00;
         port_a_oe_o <= 8'h00;
         port_b_o <= 8'h00;
         port_b_oe_o <= 8'h00;
         int_n_o <= 1'b1;
      end
      else
      begin
         access_prev_reg <= sel_access;
         ack_prev_reg <= ack_now;
         fetch_prev_reg <= fetch_now;
         if (fetch_start)
            prefix_seen_reg <= (data_i == `PPC_OPC_PREFIX);
         port_a_o <= out_a;
         port_a_oe_o <= ~dir_a;
         port_b_o <= out_b;
         port_b_oe_o <= ~dir_b;
         // in-service port blocks its own and the lower request
         int_n_o <= !((req_a && !svc_a) || (req_b && !svc_a && !svc_b));
         if (ack_start && req_a)
         begin
            data_o <= {vec_a[7:1], 1'b0};
            data_oe_o <= 1'b1;
         end
         else if (ack_start && req_b)
         begin
            data_o <= {vec_b[7:1], 1'b0};
            data_oe_o <= 1'b1;
         end
         else if (access_start && !rd_n_i && register_select_lines_i == `PPC_ADDR_A_DATA)
         begin
            data_o <= read_value(port_a_i, out_a, dir_a);
            data_oe_o <= 1'b1;
         end
         else if (access_start && !rd_n_i && register_select_lines_i == `PPC_ADDR_B_DATA)
         begin
            data_o <= read_value(port_b_i, out_b, dir_b);
            data_oe_o <= 1'b1;
         end
         else if (!sel_access && !ack_now)
            data_oe_o <= 1'b0;
      end
   end
endmodule // ppc_top

// File: tb/ppc_top_props.sv
`timescale 1ns/1ns
module ppc_top_props
(
   input wire clock_i,
   input wire rst_i,
   input wire cs_n_i,
   input wire io_request_strobe_n_i,
   input wire rd_n_i,
   input wire machine_cycle_one_strobe_n_i,
   input wire [3:0] register_select_lines_i,
   input wire [7:0] data_i,
   input wire [7:0] data_o,
   input wire data_oe_o,
   input wire [7:0] port_a_oe_o,
   input wire [7:0] port_b_oe_o,
   input wire int_n_o
);
   wire iq = io_request_strobe_n_i;
   wire fc = machine_cycle_one_strobe_n_i;
   wire wr = !cs_n_i && !iq && rd_n_i && fc;
   reg [3:0] ha_reg;
   reg [3:0] hb_reg;
   reg arm_reg;
   // direction may only move shortly after reset or a command write
   always @(posedge clock_i)
   begin
      ha_reg <= {ha_reg[2:0], rst_i | (wr && register_select_lines_i == 4'h1)};
      hb_reg <= {hb_reg[2:0], rst_i | (wr && register_select_lines_i == 4'h3)};
      if (rst_i || (wr && data_i[7] && data_i[1:0] == 2'h3 && !data_i[3]))
         arm_reg <= 1'b0;
      else if (!fc)
         arm_reg <= 1'b1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_rst;
      disable iff (1'b0) rst_i |=> int_n_o && !data_oe_o && (port_a_oe_o | port_b_oe_o) == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_wrq;
      wr [*2] |-> !data_oe_o;
   endproperty
   a_wrq: assert property (p_wrq) else $error("bus driven in write");
   property p_ack;
      $fell(iq) && !fc && !int_n_o |=> data_oe_o && !data_o[0];
   endproperty
   a_ack: assert property (p_ack) else $error("no vector on ack");
   property p_oe;
      data_oe_o |-> !$past(iq);
   endproperty
   a_oe: assert property (p_oe) else $error("stray bus drive");
   property p_dira;
      !$stable(port_a_oe_o) |-> ha_reg != 4'h0;
   endproperty
   a_dira: assert property (p_dira) else $error("stray direction a");
   property p_dirb;
      !$stable(port_b_oe_o) |-> hb_reg != 4'h0;
   endproperty
   a_dirb: assert property (p_dirb) else $error("stray direction b");
   property p_hold;
      !int_n_o && iq && $past(iq) |=> !int_n_o;
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_arm;
      $fell(int_n_o) |-> arm_reg;
   endproperty
   a_arm: assert property (p_arm) else $error("request before arm");
   c_ack: cover property ($fell(iq) && !fc && !int_n_o);
   c_int: cover property ($fell(int_n_o));
   c_dir: cover property (!$stable(port_b_oe_o));
endmodule // ppc_top_props
bind ppc_top ppc_top_props chk (.*);

// File: tb/ppc_host.sv
`timescale 1ns/1ns
module ppc_host
(
   input wire clock_i,
   input wire [7:0] bus_i,
   output reg cs_n_o,
   output reg rq_n_o,
   output reg rd_n_o,
   output reg fs_n_o,
   output reg [3:0] sel_o,
   output reg [7:0] dat_o
);
   initial
   begin
      {cs_n_o, rq_n_o, rd_n_o, fs_n_o} = 4'hF;
      sel_o = 4'h0;
      dat_o = 8'hA5;
   end
   // k 0 write, 1 acknowledge, 2 fetch, 3 read; released bus shows the inverse
   task cyc(input [1:0] k, input [3:0] a, input [7:0] d, output [7:0] q);
   begin
      @(posedge clock_i);
      sel_o <= a;
      dat_o <= d;
      cs_n_o <= k[1] ^ k[0];
      rq_n_o <= k == 2'h2;
      rd_n_o <= !k[1];
      fs_n_o <= k[1] == k[0];
      repeat (2) @(posedge clock_i);
      q = bus_i;
      {cs_n_o, rq_n_o, rd_n_o, fs_n_o} <= 4'hF;
      dat_o <= ~d;
      repeat (2) @(posedge clock_i);
   end
   endtask
endmodule // ppc_host

// File: tb/parallel_port_command_programming_tb.sv
`timescale 1ns/1ns
module parallel_port_command_programming_tb;
   reg clock_i;
   reg rst_i;
   reg [7:0] pa;
   reg [7:0] pb;
   reg [31:0] lf;
   reg [7:0] q;
   reg [7:0] va;
   reg [7:0] vb;
   reg [7:0] dw;
   reg [7:0] expq[$];
   integer n_mismatch;
   integer cmp_count;
   integer m;
   wire cs_n, rq_n, rd_n, fs_n, int_n;
   wire [3:0] sel;
   wire [7:0] db, dq, aoe, boe, pao, pbo;
   ppc_host host (.clock_i(clock_i), .bus_i(dq), .cs_n_o(cs_n), .rq_n_o(rq_n), .rd_n_o(rd_n),
      .fs_n_o(fs_n), .sel_o(sel), .dat_o(db));
   ppc_top dut (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n), .io_request_strobe_n_i(rq_n),
      .rd_n_i(rd_n), .machine_cycle_one_strobe_n_i(fs_n), .register_select_lines_i(sel),
      .data_i(db), .data_o(dq), .data_oe_o(), .port_a_i(pa), .port_a_o(pao), .port_a_oe_o(aoe),
      .port_b_i(pb), .port_b_o(pbo), .port_b_oe_o(boe), .int_n_o(int_n));
   initial
   begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   function [31:0] nx(input [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function fire(input [7:0] p, input [7:0] k, input a, input h);
      fire = a ? ((h ? p : ~p) & ~k) == ~k : |((h ? p : ~p) & ~k);
   endfunction
   task chk(input [7:0] g, input [7:0] e);
   begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   end
   endtask
   task wr(input [3:0] a, input [7:0] v);
      host.cyc(2'h0, a, v, q);
   endtask
   task pin(input [3:0] a, input [7:0] v);
   begin
      @(posedge clock_i);
      if (a == 4'h1)
         pa <= v;
      else
         pb <= v;
   end
   endtask
   task lvl(input e);
   begin
      repeat (8) @(posedge clock_i);
      chk({7'h0, int_n}, {7'h0, e});
   end
   endtask
   // condition word, mask, arm by a fetch, then move the pins
   task irq(input [3:0] a, input [7:0] w, input [7:0] k, input [7:0] p0, input [7:0] p1,
      input [7:0] v);
   begin
      wr(a, w);
      wr(a, k);
      pin(a, p0);
      pin(a, p1);
      lvl(1'b1);
      pin(a, p0);
      host.cyc(2'h2, 4'h0, 8'h00, q);
      pin(a, p1);
      lvl(!fire(p1, k, w[6], w[5]));
      if (fire(p1, k, w[6], w[5]))
         expq.push_back(v);
   end
   endtask
   task ack;
   begin
      host.cyc(2'h1, 4'h0, 8'h00, q);
      chk(q, expq.pop_front());
      host.cyc(2'h2, 4'h0, 8'hED, q);
      host.cyc(2'h2, 4'h0, 8'h4D, q);
   end
   endtask
   task final_report;
   begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge clock_i);
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t run limit", $time);
      final_report;
   end
   initial
   begin
      n_mismatch = 0;
      cmp_count = 0;
      lf = 32'hCA370826;
      pa = 8'h00;
      pb = 8'hFF;
      rst_i = 1'b1;
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      chk(aoe | boe, 8'h00);
      chk({7'h0, int_n}, 8'h01);
      for (m = 0; m < 4; m = m + 1)
      begin
         lf = nx(lf);
         wr(4'h3, {m[1:0], 6'h0F});
         if (m == 3)
            wr(4'h3, lf[7:0] | 8'h03);
         chk(boe, m == 0 ? 8'hFF : m == 3 ? ~(lf[7:0] | 8'h03) : 8'h00);
      end
      wr(4'h7, 8'h0F);
      chk(boe, ~(lf[7:0] | 8'h03));
      dw = lf[7:0] | 8'h03;
      wr(4'h1, 8'hCF);
      wr(4'h1, 8'hFF);
      chk(aoe, 8'h00);
      lf = nx(lf);
      pin(4'h1, lf[31:24]);
      wr(4'h2, lf[15:8]);
      chk(pbo, lf[15:8]);
      host.cyc(2'h3, 4'h2, 8'h00, q);
      chk(q, dw | (lf[15:8] & ~dw));
      wr(4'h0, lf[23:16]);
      chk(pao, lf[23:16]);
      host.cyc(2'h3, 4'h0, 8'h00, q);
      chk(q, pa);
      $display("mode words done");
      lf = nx(lf);
      va = {lf[7:1], 1'b0};
      vb = {lf[15:9], 1'b0};
      wr(4'h1, va);
      wr(4'h3, vb);
      irq(4'h1, 8'hB7, 8'hFE, 8'h02, 8'h03, va);
      ack;
      irq(4'h3, 8'hD7, 8'hFC, 8'hFE, 8'hFC, vb);
      ack;
      irq(4'h1, 8'hF7, 8'hFC, 8'h00, 8'h01, va);
      pin(4'h1, 8'h03);
      lvl(1'b0);
      wr(4'h1, 8'hF7);
      wr(4'h1, 8'hFC);
      host.cyc(2'h2, 4'h0, 8'h00, q);
      lvl(1'b1);
      wr(4'h1, 8'h03);
      host.cyc(2'h2, 4'h0, 8'h00, q);
      pin(4'h1, 8'h00);
      pin(4'h1, 8'h03);
      lvl(1'b1);
      wr(4'h1, 8'h83);
      host.cyc(2'h2, 4'h0, 8'h00, q);
      pin(4'h1, 8'h00);
      pin(4'h1, 8'h03);
      lvl(1'b0);
      expq.push_back(va);
      ack;
      $display("interrupt words done");
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      chk(aoe | boe, 8'h00);
      chk({7'h0, int_n}, 8'h01);
      host.cyc(2'h3, 4'h2, 8'h00, q);
      chk(q, pb);
      $display("reset words done");
      final_report;
   end
endmodule // parallel_port_command_programming_tb
